// [rtl/ovt_top.v]
// Output voltage format byte and target word with boot, restore, clamp and slew
`timescale 1ns/10ps
`include "ovt_regs.vh"

// Overview of operation
// - Format byte at code 20h: relative flag, mode field, five-bit exponent.
// - Bit 7 picks absolute (0) or relative (1); its default comes from storage.
// - Mode bits 6:5 are read-only and read 00b, linear; others are invalid.
// - Bits 4:0 hold a two's complement exponent, supported from -4 to -12.
// - Format byte is writable only while conversion is off; read-only otherwise.
// - A format change rescales stored dependent values to the new setting.
// - Values are taken in the format current at write, rescaled on later change.
// - 16-bit target at code 21h, word access; output slews toward it gradually.
// - Reset-configured power-good pin returns output and target to boot voltage.
// - Power-on or restore loads default from storage (select 0) or strap (1).
// - Boot voltage is kept apart from the target; target writes leave it alone.
// - After a fault, keep target (bit 0) or reload boot default (bit 1).
// - Target plus trim beyond limits clamps reference to the limit; a target write beyond them warns.
module ovt_top #(
  parameter TICK_CYCLES = `OVT_TICK_CYCLES
) (
  input wire mclk_in,
  input wire resetn_in,
  input wire cmd_valid_in,
  input wire cmd_write_in,
  input wire [7:0] cmd_code_in,
  input wire [15:0] cmd_wdata_in,
  input wire conv_enable_in,
  input wire power_good_reset_pin_in,
  input wire pin_is_reset_cfg_in,
  input wire strap_source_select_in,
  input wire fault_restart_default_in,
  input wire fault_shutdown_in,
  input wire restore_user_all_in,
  input wire [7:0] nvm_format_in,
  input wire [15:0] nvm_target_in,
  input wire [15:0] voltage_strap_pin_in,
  input wire [15:0] trim_in,
  input wire [15:0] limit_max_in,
  input wire [15:0] limit_min_in,
  input wire [15:0] output_slew_setting_in,
  output reg cmd_ready_out,
  output reg resp_valid_out,
  output reg [15:0] resp_data_out,
  output reg invalid_data_out,
  output reg invalid_cmd_out,
  output reg limit_warn_out,
  output reg relative_format_flag_out,
  output reg [4:0] exponent_out,
  output reg [15:0] target_out,
  output reg [15:0] boot_voltage_out,
  output wire [15:0] reference_out,
  output wire reference_settled_out
);

  localparam [2:0] S_INIT = 3'h0;
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_CV_TGT = 3'h2;
  localparam [2:0] S_CV_BOOT = 3'h3;
  localparam [2:0] S_CV_REF = 3'h4;

  // {over, under, clamped value} of target plus signed trim against the limits
  function [17:0] ovt_limit;
    input [15:0] tgt;
    input [15:0] trim;
    input [15:0] mx;
    input [15:0] mn;
    reg signed [17:0] sum;
    reg over;
    reg under;
    begin
      sum = $signed({2'b00, tgt}) + $signed({{2{trim[15]}}, trim});
      over = sum > $signed({2'b00, mx});
      under = sum < $signed({2'b00, mn});
      ovt_limit = {over, under, over ? mx : (under ? mn : sum[15:0])};
    end
  endfunction

  // Linear mode and exponent inside the supported window
  function fmt_ok;
    input [7:0] fmt;
    begin
      fmt_ok = (fmt[`OVT_FMT_MODE_HI:`OVT_FMT_MODE_LO] == `OVT_MODE_LINEAR) &&
               (fmt[`OVT_FMT_EXP_HI:`OVT_FMT_EXP_LO] >= `OVT_EXP_MIN) &&
               (fmt[`OVT_FMT_EXP_HI:`OVT_FMT_EXP_LO] <= `OVT_EXP_MAX);
    end
  endfunction

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [7:0] fmt_q;
  reg [7:0] fmt_new_q;
  reg [15:0] target_q;
  reg [15:0] boot_q;
  reg pg_meta_q;
  reg pg_sync_q;
  reg pg_prev_q;
  reg pgr_pend_q;
  reg flt_pend_q;
  reg rst_pend_q;

  wire cmd_take;
  wire wr_fmt;
  wire wr_tgt;
  wire rd_any;
  wire fmt_wr_good;
  wire [17:0] wr_chk;
  wire [17:0] goal_chk;
  wire [15:0] boot_src;
  wire pg_assert;
  wire svc_pgr;
  wire svc_flt;
  wire svc_rst;
  reg [15:0] cv_value;
  wire [15:0] cv_result;
  wire ramp_load;

  assign cmd_take = cmd_valid_in && cmd_ready_out;
  assign wr_fmt = cmd_take && cmd_write_in && (cmd_code_in == `OVT_CMD_FORMAT);
  assign wr_tgt = cmd_take && cmd_write_in && (cmd_code_in == `OVT_CMD_TARGET);
  assign rd_any = cmd_take && !cmd_write_in;
  assign fmt_wr_good = fmt_ok(cmd_wdata_in[7:0]);
  assign wr_chk = ovt_limit(cmd_wdata_in, trim_in, limit_max_in, limit_min_in);
  assign goal_chk = ovt_limit(target_q, trim_in, limit_max_in, limit_min_in);
  assign boot_src = strap_source_select_in ? voltage_strap_pin_in : nvm_target_in;

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin: outside signal, synchronised before use

  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      pg_meta_q <= 1'b0;
      pg_sync_q <= 1'b0;
      pg_prev_q <= 1'b0;
    end else begin
      pg_meta_q <= power_good_reset_pin_in;
      pg_sync_q <= pg_meta_q;
      pg_prev_q <= pg_sync_q;
    end
  end

  // Pin is active low; act on its falling edge only when set up as a reset
  assign pg_assert = pin_is_reset_cfg_in && pg_prev_q && !pg_sync_q;

  // Events wait for an idle cycle with no command; a new event beats its clear
  assign svc_rst = (state_q == S_IDLE) && !cmd_take && rst_pend_q;
  assign svc_pgr = (state_q == S_IDLE) && !cmd_take && !rst_pend_q && pgr_pend_q;
  assign svc_flt = (state_q == S_IDLE) && !cmd_take && !rst_pend_q && !pgr_pend_q && flt_pend_q;

  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      pgr_pend_q <= 1'b0;
      flt_pend_q <= 1'b0;
      rst_pend_q <= 1'b0;
    end else begin
      pgr_pend_q <= pg_assert | (pgr_pend_q & ~svc_pgr);
      flt_pend_q <= fault_shutdown_in | (flt_pend_q & ~svc_flt);
      rst_pend_q <= restore_user_all_in | (rst_pend_q & ~svc_rst);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rescaling after a format change, one stored value per cycle

  always @* begin
    case (state_q)
      S_CV_TGT: cv_value = target_q;
      S_CV_BOOT: cv_value = boot_q;
      S_CV_REF: cv_value = reference_out;
      default: cv_value = target_q;
    endcase
  end

  ovt_exp_convert u_conv (
    .value_in(cv_value),
    .exp_old_in(fmt_q[`OVT_FMT_EXP_HI:`OVT_FMT_EXP_LO]),
    .exp_new_in(fmt_new_q[`OVT_FMT_EXP_HI:`OVT_FMT_EXP_LO]),
    .value_out(cv_result)
  );

  always @* begin
    case (state_q)
      S_INIT: state_d = S_IDLE;
      S_IDLE: state_d = (wr_fmt && !conv_enable_in && fmt_wr_good) ? S_CV_TGT : S_IDLE;
      S_CV_TGT: state_d = S_CV_BOOT;
      S_CV_BOOT: state_d = S_CV_REF;
      S_CV_REF: state_d = S_IDLE;
      default: state_d = S_INIT;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stored format, target and boot voltage

  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      state_q <= S_INIT;
      fmt_q <= `OVT_FMT_RESET;
      fmt_new_q <= `OVT_FMT_RESET;
      target_q <= `OVT_TARGET_RESET;
      boot_q <= `OVT_TARGET_RESET;
    end else begin
      state_q <= state_d;
      case (state_q)
        S_INIT: begin
          // Defaults caught after reset release, mode bits forced linear
          fmt_q <= {nvm_format_in[`OVT_FMT_REL_BIT], `OVT_MODE_LINEAR,
                    nvm_format_in[`OVT_FMT_EXP_HI:`OVT_FMT_EXP_LO]};
          target_q <= boot_src;
          boot_q <= boot_src;
        end
        S_IDLE: begin
          if (wr_fmt && !conv_enable_in && fmt_wr_good) begin
            fmt_new_q <= {cmd_wdata_in[`OVT_FMT_REL_BIT], `OVT_MODE_LINEAR,
                          cmd_wdata_in[`OVT_FMT_EXP_HI:`OVT_FMT_EXP_LO]};
          end
          if (wr_tgt) begin
            target_q <= cmd_wdata_in;
          end
          if (svc_rst) begin
            fmt_q <= {nvm_format_in[`OVT_FMT_REL_BIT], `OVT_MODE_LINEAR,
                      nvm_format_in[`OVT_FMT_EXP_HI:`OVT_FMT_EXP_LO]};
            target_q <= boot_src;
            boot_q <= boot_src;
          end
          if (svc_pgr) begin
            target_q <= boot_q;
          end
          // Fault reload reuses the stored boot value; storage is not reread
          if (svc_flt && fault_restart_default_in) begin
            target_q <= boot_q;
          end
        end
        S_CV_TGT: target_q <= cv_result;
        S_CV_BOOT: boot_q <= cv_result;
        // Format switches last; until then the converter sees the old exponent
        S_CV_REF: fmt_q <= fmt_new_q;
        default: fmt_q <= fmt_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference slewing toward the clamped goal

  assign ramp_load = (state_q == S_CV_REF);

  ovt_ramp #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_ramp (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .goal_in(goal_chk[15:0]),
    .step_in(output_slew_setting_in),
    .load_in(ramp_load),
    .load_value_in(cv_result),
    .ref_out(reference_out),
    .at_goal_out(reference_settled_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Command answers and flags

  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      cmd_ready_out <= 1'b0;
      resp_valid_out <= 1'b0;
      resp_data_out <= 16'h0000;
      invalid_data_out <= 1'b0;
      invalid_cmd_out <= 1'b0;
      limit_warn_out <= 1'b0;
      relative_format_flag_out <= 1'b0;
      exponent_out <= 5'h00;
      target_out <= 16'h0000;
      boot_voltage_out <= 16'h0000;
    end else begin
      // Follows next state, so ready is low from the cycle after a good format write is taken with conversion off
      cmd_ready_out <= (state_d == S_IDLE);
      resp_valid_out <= rd_any && ((cmd_code_in == `OVT_CMD_FORMAT) || (cmd_code_in == `OVT_CMD_TARGET));
      if (rd_any && cmd_code_in == `OVT_CMD_FORMAT) begin
        resp_data_out <= {8'h00, fmt_q[`OVT_FMT_REL_BIT], `OVT_MODE_LINEAR,
                          fmt_q[`OVT_FMT_EXP_HI:`OVT_FMT_EXP_LO]};
      end else if (rd_any && cmd_code_in == `OVT_CMD_TARGET) begin
        resp_data_out <= target_q;
      end
      // Read-only while converting: write dropped without a flag
      invalid_data_out <= wr_fmt && !conv_enable_in && !fmt_wr_good;
      invalid_cmd_out <= cmd_take && (cmd_code_in != `OVT_CMD_FORMAT) && (cmd_code_in != `OVT_CMD_TARGET);
      limit_warn_out <= wr_tgt && (wr_chk[17] || wr_chk[16]);
      relative_format_flag_out <= fmt_q[`OVT_FMT_REL_BIT];
      exponent_out <= fmt_q[`OVT_FMT_EXP_HI:`OVT_FMT_EXP_LO];
      target_out <= target_q;
      boot_voltage_out <= boot_q;
    end
  end

endmodule

// [rtl/ovt_regs.vh]
// Command codes, field layout, reset values and timing for the output voltage block
`ifndef OVT_REGS_VH
`define OVT_REGS_VH

// Command codes on the command port
`define OVT_CMD_FORMAT 8'h20
`define OVT_CMD_TARGET 8'h21

// Format byte layout
`define OVT_FMT_REL_BIT 7
`define OVT_FMT_MODE_HI 6
`define OVT_FMT_MODE_LO 5
`define OVT_FMT_EXP_HI 4
`define OVT_FMT_EXP_LO 0
`define OVT_MODE_LINEAR 2'h0

// Supported exponent window, two's complement
`define OVT_EXP_MAX 5'h1c
`define OVT_EXP_MIN 5'h14

// Values held before the first load from storage
`define OVT_FMT_RESET 8'h17
`define OVT_TARGET_RESET 16'h0000

// Reference slew tick
`define OVT_CLK_PERIOD_NS 5
`define OVT_TICK_NS 1000
`define OVT_TICK_CYCLES (`OVT_TICK_NS / `OVT_CLK_PERIOD_NS)

`endif

// [rtl/ovt_exp_convert.v]
// Rescales a linear-format value from one exponent to another
`timescale 1ns/10ps
module ovt_exp_convert (
  input wire [15:0] value_in,
  input wire [4:0] exp_old_in,
  input wire [4:0] exp_new_in,
  output reg [15:0] value_out
);

  reg signed [5:0] shift;
  reg [31:0] wide;

  // Larger old exponent means coarser LSB, so the mantissa grows
  always @* begin
    shift = $signed({exp_old_in[4], exp_old_in}) - $signed({exp_new_in[4], exp_new_in});
    wide = {16'h0000, value_in};
    if (shift >= 6'sd0) begin
      wide = wide << shift[3:0];
      // Saturate rather than wrap; a wrapped voltage would be dangerous
      value_out = (wide[31:16] != 16'h0000) ? 16'hffff : wide[15:0];
    end else begin
      wide = wide >> (-shift);
      value_out = wide[15:0];
    end
  end

endmodule

// [rtl/ovt_ramp.v]
// Moves the regulation reference toward its goal at a programmed step per tick
`timescale 1ns/10ps
module ovt_ramp #(
  parameter TICK_CYCLES = 200
) (
  input wire mclk_in,
  input wire resetn_in,
  input wire [15:0] goal_in,
  input wire [15:0] step_in,
  input wire load_in,
  input wire [15:0] load_value_in,
  output reg [15:0] ref_out,
  output reg at_goal_out
);

  reg [15:0] tick_cnt_q;
  wire tick;
  wire [15:0] up_gap;
  wire [15:0] dn_gap;

  assign tick = (tick_cnt_q == 16'h0000);
  assign up_gap = goal_in - ref_out;
  assign dn_gap = ref_out - goal_in;

  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      tick_cnt_q <= 16'h0000;
      ref_out <= 16'h0000;
      at_goal_out <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? TICK_CYCLES[15:0] - 16'h0001 : tick_cnt_q - 16'h0001;
      at_goal_out <= (ref_out == goal_in) && !load_in;
      if (load_in) begin
        ref_out <= load_value_in;
      end else if (tick) begin
        // Zero step means jump straight to the goal
        if (goal_in > ref_out) begin
          ref_out <= (step_in == 16'h0000 || up_gap <= step_in) ? goal_in : ref_out + step_in;
        end else if (goal_in < ref_out) begin
          ref_out <= (step_in == 16'h0000 || dn_gap <= step_in) ? goal_in : ref_out - step_in;
        end
      end
    end
  end

endmodule

// [testbench/ovt_top_sva.sv]
// Checker for the output voltage format and target block
`timescale 1ns/10ps
`include "ovt_regs.vh"
module ovt_top_sva (
  input wire mclk_in,
  input wire resetn_in,
  input wire cmd_valid_in,
  input wire cmd_write_in,
  input wire [7:0] cmd_code_in,
  input wire [15:0] cmd_wdata_in,
  input wire conv_enable_in,
  input wire fault_shutdown_in,
  input wire fault_restart_default_in,
  input wire [15:0] trim_in,
  input wire [15:0] limit_max_in,
  input wire [15:0] limit_min_in,
  input wire cmd_ready_out,
  input wire resp_valid_out,
  input wire [15:0] resp_data_out,
  input wire invalid_data_out,
  input wire invalid_cmd_out,
  input wire limit_warn_out,
  input wire [15:0] target_out,
  input wire [15:0] boot_voltage_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  wire tk = cmd_valid_in && cmd_ready_out;
  wire mapped = cmd_code_in[7:1] == 7'h10;
  wire fw = tk && cmd_write_in && cmd_code_in == `OVT_CMD_FORMAT;
  wire bad = cmd_wdata_in[6:5] != `OVT_MODE_LINEAR || cmd_wdata_in[4:0] < `OVT_EXP_MIN ||
    cmd_wdata_in[4:0] > `OVT_EXP_MAX;
  // Trim kept at zero so the limit test stays unsigned
  wire tw = tk && cmd_write_in && cmd_code_in == `OVT_CMD_TARGET && trim_in == 16'h0000;
  wire out = cmd_wdata_in > limit_max_in || cmd_wdata_in < limit_min_in;
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_rescale;
    !cmd_ready_out [*2] ##[1:2] cmd_ready_out;
  endsequence
  sequence s_target_lands;
    !limit_warn_out ##1 target_out == $past(cmd_wdata_in, 2) && $stable(boot_voltage_out);
  endsequence
  property p_read_resp; tk && !cmd_write_in && mapped |=> resp_valid_out; endproperty
  a_read_resp: assert property (p_read_resp) else $error("read not answered");
  property p_fmt_read; tk && !cmd_write_in && cmd_code_in == `OVT_CMD_FORMAT |=>
    resp_data_out[15:8] == 8'h00 && resp_data_out[6:5] == 2'h0; endproperty
  a_fmt_read: assert property (p_fmt_read) else $error("format read shape wrong");
  property p_bad_fmt; fw && !conv_enable_in && bad |=> invalid_data_out && cmd_ready_out; endproperty
  a_bad_fmt: assert property (p_bad_fmt) else $error("bad format not flagged");
  property p_good_fmt; fw && !conv_enable_in && !bad |=> s_rescale; endproperty
  a_good_fmt: assert property (p_good_fmt) else $error("rescale busy window wrong");
  property p_locked; fw && conv_enable_in |=> cmd_ready_out && !invalid_data_out; endproperty
  a_locked: assert property (p_locked) else $error("format write taken while converting");
  property p_bad_code; tk && !mapped |=> invalid_cmd_out; endproperty
  a_bad_code: assert property (p_bad_code) else $error("unmapped code not flagged");
  property p_clamp; tw && out |=> limit_warn_out; endproperty
  a_clamp: assert property (p_clamp) else $error("limit warning missing");
  property p_target; tw && !out |=> s_target_lands; endproperty
  a_target: assert property (p_target) else $error("target write wrong");
  property p_fault; fault_shutdown_in && fault_restart_default_in && cmd_ready_out && !cmd_valid_in |=>
    ##[1:6] target_out == boot_voltage_out; endproperty
  a_fault: assert property (p_fault) else $error("fault reload missing");
endmodule

// [testbench/ovt_host.sv]
// Host controller model driving the command port
`timescale 1ns/10ps
module ovt_host (
  input wire clk_in,
  input wire ready_in,
  output reg valid_out,
  output reg write_out,
  output reg [7:0] code_out,
  output reg [15:0] wdata_out,
  output reg conv_out
);
  // Requests that never saw ready; the bench counts them as mismatches
  integer stalls = 0;
  initial begin
    valid_out = 0;
    write_out = 0;
    code_out = 8'h00;
    wdata_out = 16'h0000;
    conv_out = 0;
  end
  // Request held until ready seen at a rising edge
  task xfer(input w, input [7:0] c, input [15:0] d);
    integer n;
    begin
      @(negedge clk_in);
      valid_out = 1;
      write_out = w;
      code_out = c;
      wdata_out = d;
      n = 0;
      @(posedge clk_in);
      while (ready_in !== 1'b1 && n < 200) begin
        n = n + 1;
        @(posedge clk_in);
      end
      if (n == 200) stalls = stalls + 1;
      @(negedge clk_in);
      valid_out = 0;
      code_out = ~c;
      wdata_out = ~d;
    end
  endtask
  task set_conv(input e);
    begin
      @(negedge clk_in);
      conv_out = e;
    end
  endtask
endmodule

// [testbench/ovt_top_tb.sv]
// Self-checking testbench for the output voltage block
`timescale 1ns/10ps
module ovt_top_tb;
  reg mclk_in, resetn_in, pin_n, sel, frd, flt, rall;
  reg pcfg;
  reg [15:0] trim, slew, lmax, lmin;
  wire v, w, conv, rdy, rv, idat, icmd, warn, relative_format_flag, settled;
  wire [7:0] code;
  wire [4:0] expo;
  wire [15:0] wd, rd_d, tgt, boot, refv;
  integer bad_count = 0, compares = 0;
  reg [15:0] exp_q[$];
  reg [15:0] r;
  ovt_host host_inst (.clk_in(mclk_in), .ready_in(rdy), .valid_out(v), .write_out(w), .code_out(code),
    .wdata_out(wd), .conv_out(conv));
  ovt_top #(.TICK_CYCLES(4)) ovt_top_inst (.mclk_in(mclk_in), .resetn_in(resetn_in), .cmd_valid_in(v),
    .cmd_write_in(w), .cmd_code_in(code), .cmd_wdata_in(wd), .conv_enable_in(conv),
    .power_good_reset_pin_in(pin_n), .pin_is_reset_cfg_in(pcfg), .strap_source_select_in(sel),
    .fault_restart_default_in(frd), .fault_shutdown_in(flt), .restore_user_all_in(rall),
    .nvm_format_in(8'h1c), .nvm_target_in(16'h0123), .voltage_strap_pin_in(16'h0456), .trim_in(trim),
    .limit_max_in(lmax), .limit_min_in(lmin), .output_slew_setting_in(slew),
    .cmd_ready_out(rdy), .resp_valid_out(rv), .resp_data_out(rd_d), .invalid_data_out(idat),
    .invalid_cmd_out(icmd), .limit_warn_out(warn), .relative_format_flag_out(relative_format_flag), .exponent_out(expo),
    .target_out(tgt), .boot_voltage_out(boot), .reference_out(refv), .reference_settled_out(settled));
  initial begin
    mclk_in = 0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input [8*8:1] n, input [15:0] e, input [15:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("MISMATCH %0s expected %h seen %h", n, e, g);
      end
    end
  endtask
  task rd(input [7:0] c, input [15:0] e);
    begin
      exp_q.push_back(e);
      host_inst.xfer(1'b0, c, 16'h0000);
    end
  endtask
  task wr(input [7:0] c, input [15:0] d);
    host_inst.xfer(1'b1, c, d);
  endtask
  task ev(input k);
    begin
      @(negedge mclk_in);
      if (k) rall = 1;
      else flt = 1;
      @(negedge mclk_in);
      rall = 0;
      flt = 0;
      repeat (8) @(negedge mclk_in);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Read answers paired with the oldest expectation
  always @(posedge mclk_in) if (rv === 1'b1) chk("resp", exp_q.size() ? exp_q.pop_front() : ~rd_d, rd_d);
  initial begin
    #20000;
    bad_count = bad_count + 1;
    $display("MISMATCH watchdog expected finish seen hang");
    results;
  end
  initial begin
    resetn_in = 0;
    pin_n = 1;
    pcfg = 1;
    sel = 0;
    frd = 0;
    flt = 0;
    rall = 0;
    trim = 16'h0000;
    slew = 16'h0000;
    lmax = 16'h0800;
    lmin = 16'h0010;
    r = $urandom(1);
    repeat (2) @(negedge mclk_in);
    resetn_in = 1;
    rd(8'h20, 16'h001c);
    rd(8'h21, 16'h0123);
    chk("boot", 16'h0123, boot);
    chk("expo", 16'h001c, expo);
    $display("test defaults done");
    repeat (4) begin
      r = $urandom % 2032;
      r = r + 16'h0010;
      wr(8'h21, r);
      rd(8'h21, r);
    end
    chk("boot", 16'h0123, boot);
    wr(8'h21, 16'h0900);
    chk("warn", 16'h0001, warn);
    repeat (12) @(negedge mclk_in);
    chk("ref", 16'h0800, refv);
    wr(8'h21, 16'h0008);
    chk("warn", 16'h0001, warn);
    repeat (12) @(negedge mclk_in);
    chk("ref", 16'h0010, refv);
    // Trim counts toward the limits, with its sign
    trim = 16'h0100;
    wr(8'h21, 16'h0780);
    chk("warn", 16'h0001, warn);
    trim = 16'hff00;
    wr(8'h21, 16'h0200);
    chk("warn", 16'h0000, warn);
    repeat (12) @(negedge mclk_in);
    chk("ref", 16'h0100, refv);
    // Four ticks of 40h from 100h to 200h
    trim = 16'h0000;
    slew = 16'h0040;
    repeat (6) @(negedge mclk_in);
    chk("settled", 16'h0000, settled);
    repeat (20) @(negedge mclk_in);
    chk("ref", 16'h0200, refv);
    chk("settled", 16'h0001, settled);
    slew = 16'h0000;
    lmax = 16'h0600;
    wr(8'h21, 16'h0700);
    chk("warn", 16'h0001, warn);
    repeat (12) @(negedge mclk_in);
    chk("ref", 16'h0600, refv);
    lmax = 16'h0800;
    lmin = 16'h0300;
    wr(8'h21, 16'h0200);
    chk("warn", 16'h0001, warn);
    lmin = 16'h0010;
    $display("test targets done");
    host_inst.set_conv(1'b1);
    wr(8'h20, 16'h009c);
    rd(8'h20, 16'h001c);
    host_inst.set_conv(1'b0);
    wr(8'h20, 16'h00bc);
    chk("invdata", 16'h0001, idat);
    wr(8'h20, 16'h009d);
    chk("invdata", 16'h0001, idat);
    wr(8'h20, 16'h0093);
    chk("invdata", 16'h0001, idat);
    wr(8'h21, 16'h0100);
    wr(8'h20, 16'h009b);
    repeat (4) @(negedge mclk_in);
    rd(8'h20, 16'h009b);
    chk("rel", 16'h0001, relative_format_flag);
    chk("expo", 16'h001b, expo);
    rd(8'h21, 16'h0200);
    chk("boot", 16'h0246, boot);
    wr(8'h22, 16'h0000);
    chk("invcmd", 16'h0001, icmd);
    $display("test format done");
    wr(8'h21, 16'h0300);
    ev(1'b0);
    rd(8'h21, 16'h0300);
    frd = 1;
    ev(1'b0);
    rd(8'h21, 16'h0246);
    // Pin not set up as a reset: pulse must leave the target alone
    pcfg = 0;
    wr(8'h21, 16'h0300);
    pin_n = 0;
    repeat (8) @(negedge mclk_in);
    pin_n = 1;
    repeat (4) @(negedge mclk_in);
    rd(8'h21, 16'h0300);
    pcfg = 1;
    pin_n = 0;
    repeat (8) @(negedge mclk_in);
    pin_n = 1;
    rd(8'h21, 16'h0246);
    $display("test events done");
    sel = 1;
    ev(1'b1);
    rd(8'h21, 16'h0456);
    rd(8'h20, 16'h001c);
    chk("boot", 16'h0456, boot);
    chk("target", 16'h0456, tgt);
    chk("expo", 16'h001c, expo);
    $display("test restore done");
    repeat (4) @(negedge mclk_in);
    chk("queue", 16'h0000, exp_q.size());
    chk("stalls", 16'h0000, host_inst.stalls[15:0]);
    results;
  end
endmodule
bind ovt_top ovt_top_sva ovt_top_sva_inst (.*);
